// [hw/cips_seq.sv]
// Sequencer controlling the pass switch, soft-start ramp and fault output.
`timescale 1ns/1ps
module cips_seq #(
  parameter int unsigned PGOOD_CYCLES = cips_pkg::PGOOD_CYC,
  parameter int unsigned STEP_CYCLES = cips_pkg::STEP_CYC,
  parameter int unsigned OV_REC_CYCLES = cips_pkg::OV_REC_CYC,
  parameter int unsigned RETRY_CYCLES = cips_pkg::RETRY_CYC,
  parameter int unsigned SSTOP_CYCLES = cips_pkg::SSTOP_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire cips_pkg::cips_sense_t SENSE,
  output cips_pkg::cips_drive_t DRIVE,
  output logic FAULT_N_O,
  output logic FAULT_N_OE
);
  import cips_pkg::*;

  typedef struct packed {
    cips_state_t st;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] bat_tmr;
    logic bat_fault;
    logic [2:0] step;
    logic ov_seen;
    logic sc_fault;
    cips_drive_t drv;
    logic fault_oe;
  } cips_regs_t;

  // ----------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------
  cips_sense_t s;

  cips_sync #(.W(SYNC_W)) u_sync ( // [R25]
    .CLK(CLK),
    .RST(RST),
    .D(SENSE),
    .Q(s)
  );

  cips_regs_t r_q;
  cips_regs_t r_d;
  logic block_on;
  logic any_fault;

  function automatic logic [TMR_W-1:0] cyc(input int unsigned n);
    cyc = TMR_W'(n - 1);
  endfunction : cyc

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    // Battery overvoltage must persist for the qualification time.
    if (!s.battery_over) begin
      r_d.bat_tmr = '0;
      r_d.bat_fault = 1'b0; // [R15]
    end else if (!r_q.bat_fault) begin
      if (r_q.bat_tmr == cyc(BAT_DGL_CYC)) begin
        r_d.bat_fault = 1'b1; // [R22]
      end else begin
        r_d.bat_tmr = r_q.bat_tmr + 1'b1;
      end
    end
    // Conditions that hold the switch off; all must clear before restart.
    block_on = s.input_over | r_q.bat_fault | s.over_temp | s.enable_n; // [R26]
    any_fault = s.input_over | r_q.bat_fault | s.over_temp; // [R19]
    if (s.input_over) begin
      r_d.ov_seen = 1'b1;
    end
    r_d.tmr = (r_q.tmr == '0) ? '0 : r_q.tmr - 1'b1;
    unique case (r_q.st)
      ST_DOWN: begin
        r_d.tmr = cyc(PGOOD_CYCLES); // [R4]
        r_d.ov_seen = 1'b0;
        r_d.sc_fault = 1'b0;
        if (!s.undervoltage_lockout) begin
          r_d.st = ST_PGOOD; // [R3]
        end
      end
      ST_PGOOD: begin
        if (r_q.tmr == '0 && !block_on) begin
          r_d.st = ST_RAMP; // [R5] [R18]
          r_d.step = 3'h0;
          r_d.tmr = cyc(STEP_CYCLES);
          r_d.drv.gate_on = 1'b1;
          r_d.drv.sense_on = 1'b1;
          r_d.drv.current_limit = LIM_FULL >> 3; // [R7]
        end else if (r_q.tmr == '0) begin
          r_d.st = ST_OFF;
        end
      end
      ST_RAMP: begin
        if (r_q.tmr == '0) begin
          if (r_q.step == 3'h7) begin
            // Single sample of the comparator at ramp end.
            if (s.over_current) begin // [R8]
              r_d.st = ST_SSTOP; // [R9]
              r_d.drv.soft_stop = 1'b1; // [R11]
              r_d.sc_fault = 1'b1;
              r_d.tmr = cyc(SSTOP_CYCLES);
            end else begin
              r_d.st = ST_RUN;
              r_d.drv.sense_on = 1'b0; // [R10]
            end
          end else begin
            r_d.step = r_q.step + 3'h1; // [R6]
            r_d.drv.current_limit = r_q.drv.current_limit + (LIM_FULL >> 3); // [R7]
            r_d.tmr = cyc(STEP_CYCLES);
          end
        end
      end
      ST_RUN: begin
        // Overcurrent is deliberately not observed here.
      end
      ST_OFF: begin
        if (!block_on) begin
          if (r_q.ov_seen) begin
            r_d.ov_seen = 1'b0;
            r_d.st = ST_PGOOD;
            r_d.tmr = cyc(OV_REC_CYCLES); // [R14] [R21]
          end else begin
            r_d.st = ST_PGOOD;
            r_d.tmr = '0;
          end
        end
      end
      ST_SSTOP: begin
        if (r_q.tmr == '0) begin
          r_d.drv.gate_on = 1'b0;
          r_d.drv.soft_stop = 1'b0;
          r_d.drv.current_limit = LIM_RST;
          r_d.st = ST_RETRY;
          // The retry interval runs from the start of soft-stop, so it includes that time.
          r_d.tmr = cyc(RETRY_CYCLES - SSTOP_CYCLES);
        end
      end
      ST_RETRY: begin
        if (r_q.tmr == '0) begin
          r_d.sc_fault = 1'b0; // [R23]
          r_d.st = ST_PGOOD;
        end
      end
      default: r_d.st = ST_DOWN;
    endcase
    // Immediate off for protection or disable, overriding the sequence.
    if (block_on && r_q.st inside {ST_RAMP, ST_RUN, ST_SSTOP, ST_RETRY, ST_PGOOD}
        && !(r_q.st == ST_PGOOD && r_q.tmr != '0)) begin
      r_d.st = ST_OFF; // [R12] [R15] [R16] [R17]
      r_d.drv.gate_on = 1'b0;
      r_d.drv.soft_stop = 1'b0;
      r_d.drv.sense_on = 1'b0;
      r_d.drv.current_limit = LIM_RST;
      r_d.sc_fault = 1'b0;
    end
    if (block_on && r_q.st == ST_PGOOD && r_q.tmr != '0 && s.input_over) begin
      r_d.st = ST_OFF; // [R14]
    end
    r_d.fault_oe = !s.enable_n && (any_fault || r_d.sc_fault); // [R13] [R19] [R20] [R24]
    if (s.undervoltage_lockout) begin
      r_d = '0; // [R1] [R2]
      r_d.st = ST_DOWN;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign DRIVE = r_q.drv;
  assign FAULT_N_O = 1'b0;
  assign FAULT_N_OE = r_q.fault_oe;

endmodule : cips_seq

// [hw/cips_pkg.sv]
// Package of constants and types for the charger input protection sequencer.
// Overview of operation
// R1 - Below lockout: power-down, switch off, fault released
// R2 - Power-down: gate deasserted, fault not pulled
// R3 - Rising above lockout restarts the sequence
// R4 - Wait power-good deglitch before deciding switch-on
// R5 - Switch on only without input or battery overvoltage
// R6 - Soft-start: eight steps, one every 625 us
// R7 - Each step is one eighth of limit
// R8 - Sample overcurrent once after final step
// R9 - Overcurrent at sample enters short-circuit protection
// R10 - No overcurrent: ignore overcurrent during normal run
// R11 - Short-circuit switch-off uses gradual soft-stop
// R12 - Input overvoltage turns switch off immediately
// R13 - Input overvoltage switch-off drives fault low
// R14 - Re-enable after overvoltage only after recovery deglitch
// R15 - Battery overvoltage keeps switch off until release
// R16 - Overtemperature switches the pass switch off
// R17 - Enable high forces switch off
// R18 - Enable low turns switch on via sequence
// R19 - Fault low when off due to protection
// R20 - No fault in normal run: fault released
// R21 - Recovery deglitch is 8 ms
// R22 - Battery overvoltage qualified for 176 us
// R23 - Short-circuit retry after 64 ms, then restart
// R24 - Enable high keeps fault released always
// R25 - Synchronise comparator and enable inputs first
// R26 - Multiple faults: off and fault until all clear
package cips_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned STEP_TIME_US = 625;
  localparam int unsigned BAT_DGL_TIME_US = 176;
  localparam int unsigned OV_REC_TIME_MS = 8;
  localparam int unsigned RETRY_TIME_MS = 64;
  localparam int unsigned PGOOD_DGL_TIME_US = 1000;
  localparam int unsigned SOFT_STOP_TIME_US = 100;
  localparam int unsigned STEP_CYC = STEP_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BAT_DGL_CYC = BAT_DGL_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OV_REC_CYC = OV_REC_TIME_MS * (CLK_HZ / 1_000);
  localparam int unsigned RETRY_CYC = RETRY_TIME_MS * (CLK_HZ / 1_000);
  localparam int unsigned PGOOD_CYC = PGOOD_DGL_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SSTOP_CYC = SOFT_STOP_TIME_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------------
  localparam int TMR_W = 24;
  localparam int LIM_W = 4;
  localparam logic [LIM_W-1:0] LIM_FULL = 4'h8;
  localparam logic [LIM_W-1:0] LIM_RST = 4'h0;
  localparam int SYNC_W = 6;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_DOWN = 3'b000,
    ST_PGOOD = 3'b001,
    ST_RAMP = 3'b011,
    ST_RUN = 3'b010,
    ST_OFF = 3'b110,
    ST_SSTOP = 3'b111,
    ST_RETRY = 3'b101
  } cips_state_t;

  typedef struct packed {
    logic undervoltage_lockout;
    logic input_over;
    logic battery_over;
    logic over_temp;
    logic over_current;
    logic enable_n;
  } cips_sense_t;

  typedef struct packed {
    logic gate_on;
    logic [LIM_W-1:0] current_limit;
    logic sense_on;
    logic soft_stop;
  } cips_drive_t;

endpackage : cips_pkg

// [hw/cips_sync.sv]
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module cips_sync #(
  parameter int W = 1
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [W-1:0] D,
  output logic [W-1:0] Q
);
  logic [W-1:0] meta_q;

  // The first stage is read only by the second.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      meta_q <= '0;
      Q <= '0;
    end else begin
      meta_q <= D;
      Q <= meta_q;
    end
  end
endmodule : cips_sync

// [tb/cips_seq_props.sv]
// Port checker for the charger input protection sequencer.
`timescale 1ns/1ps
module cips_seq_props #(
  parameter int unsigned STEP_CYCLES = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire cips_pkg::cips_sense_t SENSE,
  input wire cips_pkg::cips_drive_t DRIVE,
  input wire logic FAULT_N_O,
  input wire logic FAULT_N_OE
);
  import cips_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [13:0] bat_q;
  logic [13:0] hold_q;
  // The battery count saturates so a long event cannot wrap back below the limit.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bat_q <= '0;
      hold_q <= '0;
    end else begin
      bat_q <= !SENSE.battery_over ? '0 : (bat_q == '1) ? bat_q : bat_q + 14'h1;
      hold_q <= $changed(DRIVE.current_limit) ? '0 : hold_q + 14'h1;
    end
  end
  lock_off_a: assert property (
    SENSE.undervoltage_lockout [*4] |=> !DRIVE.gate_on && !FAULT_N_OE)
    else $error("switch or fault active below lockout");
  en_off_a: assert property (SENSE.enable_n [*4] |=> !DRIVE.gate_on && !FAULT_N_OE)
    else $error("switch or fault active while disabled");
  ovp_off_a: assert property (SENSE.input_over [*4] |=> !DRIVE.gate_on)
    else $error("switch on during input overvoltage");
  step_up_a: assert property (DRIVE.current_limit > $past(DRIVE.current_limit) |->
    DRIVE.current_limit == $past(DRIVE.current_limit) + 4'h1)
    else $error("limit rose by more than one step");
  step_time_a: assert property (DRIVE.current_limit > $past(DRIVE.current_limit) &&
    $past(DRIVE.current_limit) != 4'h0 |-> $past(hold_q) + 1 inside {[STEP_CYCLES-1:STEP_CYCLES]})
    else $error("soft-start step length wrong");
  bat_off_a: assert property (bat_q > 14'(BAT_DGL_CYC + 4) |-> !DRIVE.gate_on)
    else $error("switch on after battery overvoltage qualified");
  run_clean_a: assert property ((DRIVE.gate_on && !DRIVE.soft_stop) [*3] |-> !FAULT_N_OE)
    else $error("fault pulled during normal run");
  stop_fault_a: assert property ($rose(DRIVE.soft_stop) |-> ##[0:1] FAULT_N_OE)
    else $error("soft-stop without fault");
  cover property ($rose(DRIVE.soft_stop));
  cover property (DRIVE.current_limit == LIM_FULL);
  cover property ($rose(FAULT_N_OE));
endmodule : cips_seq_props
bind cips_seq cips_seq_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (.CLK(CLK), .RST(RST),
  .SENSE(SENSE), .DRIVE(DRIVE), .FAULT_N_O(FAULT_N_O), .FAULT_N_OE(FAULT_N_OE));

// [tb/cips_host.sv]
// Host model: drives the enable line and reads the open-drain fault line.
`timescale 1ns/1ps
module cips_host (
  input wire logic CLK,
  input wire logic want_off,
  input wire logic FAULT_N_O,
  input wire logic FAULT_N_OE,
  output logic enable_n,
  output logic fault_n
);
  // The fault line has a pull-up, so a released driver reads high.
  assign fault_n = FAULT_N_OE ? FAULT_N_O : 1'b1;
  initial enable_n = 1'b0;
  always @(negedge CLK) enable_n <= want_off;
endmodule : cips_host

// [tb/cips_seq_tb_top.sv]
// Self-checking bench for the charger input protection sequencer.
`timescale 1ns/1ps
module cips_seq_tb_top;
  import cips_pkg::*;
  localparam int STP = 8;
  localparam int UV = 4, OV = 3, BV = 2, OT = 1, OC = 0;
  logic CLK, RST, off, flt_n, en_n, fo, foe;
  logic [4:0] cmp;
  cips_drive_t d;
  int n_fail, tests_run, cyc_n = 0;
  logic [31:0] lf;
  cips_seq #(.PGOOD_CYCLES(4), .STEP_CYCLES(STP), .OV_REC_CYCLES(20), .RETRY_CYCLES(60),
    .SSTOP_CYCLES(5)) dut (.CLK(CLK), .RST(RST), .SENSE(cips_sense_t'({cmp, en_n})),
    .DRIVE(d), .FAULT_N_O(fo), .FAULT_N_OE(foe));
  cips_host host (.CLK(CLK), .want_off(off), .FAULT_N_O(fo), .FAULT_N_OE(foe),
    .enable_n(en_n), .fault_n(flt_n));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [3:0] step_lim(input int k);
    return 4'(k * LIM_FULL / 8);
  endfunction : step_lim
  function automatic logic pick(input int k);
    return k == 0 ? d.gate_on : k == 1 ? d.soft_stop : flt_n;
  endfunction : pick
  task automatic chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask : cyc
  task automatic wait_sig(input int k, input logic v, input int lim);
    int i;
    i = 0;
    while (pick(k) !== v && i < lim) begin
      cyc(1);
      i++;
    end
    chk("wait", 4'(pick(k)), 4'(v));
  endtask : wait_sig
  task automatic ramp();
    int i;
    wait_sig(0, 1'b1, 120);
    for (int k = 1; k <= 8; k++) begin
      i = 0;
      while (d.current_limit !== step_lim(k) && i < STP + 4) begin
        cyc(1);
        i++;
      end
      chk("limit", d.current_limit, step_lim(k));
    end
    // The full limit is held for one whole step before the single sample.
    cyc(STP + 4);
    chk("sense", 4'(d.sense_on), 4'h0);
    chk("run fault", 4'(flt_n), 4'h1);
  endtask : ramp
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // The whole run needs about 10000 cycles; the ceiling leaves ample slack.
  always @(posedge CLK) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n > 40000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    RST = 1'b1;
    off = 1'b0;
    cmp = 5'h18;
    lf = 32'h4e65;
    n_fail = 0;
    tests_run = 0;
    cyc(6);
    RST = 1'b0;
    cyc(10);
    chk("down gate", 4'(d.gate_on), 4'h0);
    chk("down fault", 4'(flt_n), 4'h1);
    cmp[UV] = 1'b0;
    cyc(30);
    chk("ov start", 4'(d.gate_on), 4'h0);
    cmp[OV] = 1'b0;
    ramp();
    repeat (40) begin
      lf = lfsr(lf);
      cmp[OC] = lf[0];
      cyc(1);
      chk("run gate", 4'(d.gate_on), 4'h1);
    end
    cmp[OC] = 1'b0;
    cmp[OV] = 1'b1;
    cmp[OT] = 1'b1;
    cyc(5);
    chk("ov gate", 4'(d.gate_on), 4'h0);
    chk("ov fault", 4'(flt_n), 4'h0);
    cmp[OT] = 1'b0;
    cyc(40);
    chk("both gate", 4'(d.gate_on), 4'h0);
    chk("both fault", 4'(flt_n), 4'h0);
    cmp[OV] = 1'b0;
    cyc(10);
    chk("recover", 4'(d.gate_on), 4'h0);
    ramp();
    off = 1'b1;
    cmp[OT] = 1'b1;
    cyc(10);
    chk("off gate", 4'(d.gate_on), 4'h0);
    chk("off fault", 4'(flt_n), 4'h1);
    off = 1'b0;
    cyc(10);
    chk("ot fault", 4'(flt_n), 4'h0);
    cmp[OT] = 1'b0;
    ramp();
    cmp[BV] = 1'b1;
    cyc(100);
    chk("bat early", 4'(d.gate_on), 4'h1);
    cyc(BAT_DGL_CYC);
    chk("bat gate", 4'(d.gate_on), 4'h0);
    chk("bat fault", 4'(flt_n), 4'h0);
    cmp[BV] = 1'b0;
    ramp();
    cmp[UV] = 1'b1;
    cyc(6);
    cmp[OC] = 1'b1;
    cmp[UV] = 1'b0;
    wait_sig(1, 1'b1, 150);
    chk("sc fault", 4'(flt_n), 4'h0);
    cmp[OC] = 1'b0;
    cyc(50);
    chk("retry hold", 4'(flt_n), 4'h0);
    wait_sig(2, 1'b1, 80);
    ramp();
    end_sim();
  end
endmodule : cips_seq_tb_top
